// ### verilog/dsh_device.sv
// dsh_device.sv: safe homing logic of the second, diverse position channel
// assumes home switch and positions are synchronous to sys_clk
// Function
// - static: high switch at standstill sets reference
// - dynamic: configured edge while moving sets reference
// - configuration selects static or dynamic evaluation
// - align channel 2 to channel 1 position
// - valid only if difference within tolerance
// - start by digital input or parameter
// - control starts only with channel 1 homed; the control's drive homing start is not gated by ch1_homed
// - device makes no motion; control moves axis
// - drive homing auto-starts channel 2 command when monitored position is configured
// - control actuates switch if travel misses it
// - status reports safe reference present
// - external encoder selects second feedback set
// - drive homing positions at reference distance
// - integrator sets tolerance accuracy plus ten percent
// - success flags status, permits monitored position
// - leaving phase 4 discards reference
// - failure raises safe homing error diagnostic
`timescale 1ns/1ps
`include "dsh_map.svh"
module dsh_device
    import dsh_pkg::*;
#(
    parameter int POS_W = `DSH_POS_W
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    dsh_if.dev                    link,
    input  wire logic             home_switch,     // channel 2 home switch input
    input  wire logic             ch2_start_in,    // digital input start of channel 2 command
    input  wire logic [POS_W-1:0] fb1_pos,         // position feedback 1 (motor encoder)
    input  wire logic [POS_W-1:0] fb2_pos,         // position feedback 2 (external encoder)
    input  wire logic [POS_W-1:0] ch2_raw_pos,     // channel 2 raw position
    output logic      [POS_W-1:0] ch2_actual_pos,  // channel 2 referenced position
    output logic                  ch2_homed,       // safe reference present
    output logic                  no_motion_req    // device never requests motion
);
    dsh_state_t       state_ff;        // sequence state
    logic [POS_W-1:0] offset_ff;       // channel 2 reference offset
    logic             sw_prev_ff;      // previous home switch level
    logic             homed_ff;        // safe reference valid
    logic             err_ff;          // error diagnostic pulse
    logic [POS_W-1:0] cap_pos_ff;      // channel 2 position at reference event
    logic [POS_W-1:0] ch2_pos_ff;      // referenced channel 2 position
    logic [POS_W-1:0] ch1_pos;         // selected channel 1 position
    logic             cfg_static;      // static evaluation chosen
    logic             edge_hit;        // configured edge seen
    logic             ref_event;       // reference event this cycle
    logic             start_req;       // digital input, parameter or monitored-position drive homing start
    logic             in_phase;        // in run phase
    logic [POS_W-1:0] diff;            // channel difference magnitude
    logic [POS_W-1:0] raw_diff;        // signed difference
    logic [POS_W-1:0] nxt_offset;      // aligned offset

    assign ch1_pos    = link.safety_cfg[`DSH_CFG_ENC2_BIT] ? fb2_pos : fb1_pos;
    assign cfg_static = link.safety_cfg[`DSH_CFG_STATIC_BIT];
    assign in_phase   = (link.comm_phase == `DSH_PHASE_RUN);
    // edge polarity picked by configuration
    assign edge_hit   = link.safety_cfg[`DSH_CFG_EDGE_BIT] ? (home_switch && !sw_prev_ff)
                                                           : (!home_switch && sw_prev_ff);
    // static: level at standstill; dynamic: edge during motion
    assign ref_event  = cfg_static ? (home_switch && !link.axis_moving)
                                   : (edge_hit && link.axis_moving);
    // drive homing starts channel 2 only with monitored position configured
    assign start_req  = ch2_start_in || link.ch2_cmd_start
                     || (link.drv_homing_start
                         && link.safety_cfg[`DSH_CFG_SMP_BIT]);
    // channel 2 position as referenced to the captured event
    assign nxt_offset = POS_W'(link.ref_pos - cap_pos_ff);
    assign raw_diff   = POS_W'(ch1_pos - (ch2_raw_pos + nxt_offset));
    assign diff       = raw_diff[POS_W-1] ? POS_W'(-raw_diff) : raw_diff;

    // switch history for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_prev_ff <= 1'b0;
        end else begin
            sw_prev_ff <= home_switch;
        end
    end

    // homing sequence; phase loss aborts everything
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= DSH_IDLE;
        end else if (!in_phase) begin
            state_ff <= DSH_IDLE;
        end else begin
            case (state_ff)
                DSH_IDLE:  if (start_req) begin
                    state_ff <= DSH_WAIT;
                end
                // waits for control-unit travel, no motion of its own
                DSH_WAIT:  if (ref_event) begin
                    state_ff <= DSH_ALIGN;
                end
                DSH_ALIGN: state_ff <= DSH_DONE;
                DSH_DONE:  state_ff <= DSH_IDLE;
                default:   state_ff <= DSH_IDLE;
            endcase
        end
    end

    // capture channel 2 raw position at the reference event
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_pos_ff <= '0;
        end else if (state_ff == DSH_WAIT && ref_event) begin
            cap_pos_ff <= ch2_raw_pos;
        end
    end

    // alignment to channel 1 with tolerance check
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_ff <= '0;
            homed_ff  <= 1'b0;
            err_ff    <= 1'b0;
        end else begin
            err_ff <= 1'b0;
            if (!in_phase) begin
                homed_ff <= 1'b0;
            end else if (state_ff == DSH_IDLE && start_req) begin
                homed_ff <= 1'b0;              // new command drops old reference
            end else if (state_ff == DSH_ALIGN) begin
                if (diff <= link.tol_window) begin
                    offset_ff <= POS_W'(ch1_pos - ch2_raw_pos);
                    homed_ff  <= 1'b1;
                end else begin
                    homed_ff  <= 1'b0;
                    err_ff    <= 1'b1;
                end
            end
        end
    end

    // referenced channel 2 position, registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ch2_pos_ff <= '0;
        end else begin
            ch2_pos_ff <= POS_W'(ch2_raw_pos + offset_ff);
        end
    end

    // operating status and outputs, all registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.op_status              <= '0;
            link.safe_homing_error_diag <= 1'b0;
            ch2_homed                   <= 1'b0;
            no_motion_req               <= 1'b0;
            ch2_actual_pos              <= '0;
        end else begin
            link.op_status[`DSH_STS_HOMED_BIT] <= homed_ff;
            link.op_status[`DSH_STS_BUSY_BIT]  <= (state_ff != DSH_IDLE);
            link.op_status[`DSH_STS_SMP_BIT]   <= homed_ff
                && link.safety_cfg[`DSH_CFG_SMP_BIT];
            link.safe_homing_error_diag        <= err_ff;
            ch2_homed                          <= homed_ff;
            no_motion_req                      <= 1'b0;
            ch2_actual_pos                     <= ch2_pos_ff;
        end
    end
endmodule : dsh_device

// ### shared/dsh_map.svh
// dsh_map.svh: widths, field positions and the run phase value for safe homing
// assumes inclusion by bare name from the package and the design modules
`ifndef DSH_MAP_SVH
`define DSH_MAP_SVH
`define DSH_POS_W          32        // position word width
`define DSH_CFG_STATIC_BIT 0         // config bit: 1 = static evaluation
`define DSH_CFG_EDGE_BIT   1         // config bit: 1 = rising edge, 0 = falling
`define DSH_CFG_SMP_BIT    2         // config bit: safely-monitored position configured
`define DSH_CFG_ENC2_BIT   3         // config bit: external encoder is channel 1
`define DSH_CFG_W          4         // config word width
`define DSH_STS_HOMED_BIT  0         // status bit: safe reference present
`define DSH_STS_BUSY_BIT   1         // status bit: channel 2 command running
`define DSH_STS_SMP_BIT    2         // status bit: monitored position permitted
`define DSH_STS_W          3         // status word width
`define DSH_PHASE_RUN      3'h4      // communication phase where reference is kept
`endif

// ### shared/dsh_pkg.sv
// dsh_pkg.sv: types shared by both ends of the safe homing link
// assumes dsh_map.svh is on the include path
`include "dsh_map.svh"
package dsh_pkg;
    typedef logic [`DSH_POS_W-1:0] dsh_pos_t;   // signed position in increments
    // channel 2 homing sequence, one-hot
    typedef enum logic [3:0] {
        DSH_IDLE  = 4'h1,
        DSH_WAIT  = 4'h2,
        DSH_ALIGN = 4'h4,
        DSH_DONE  = 4'h8
    } dsh_state_t;
endpackage : dsh_pkg

// ### shared/dsh_if.sv
// dsh_if.sv: link between the motion control unit and the safe homing logic
// assumes one clock for both ends; the bench joins the two modports
`timescale 1ns/1ps
`include "dsh_map.svh"
interface dsh_if;
    import dsh_pkg::*;
    logic                  ch2_cmd_start;    // parameter-write start of channel 2 command
    logic                  drv_homing_start; // start of drive-controlled homing command
    logic                  drv_homing_done;  // drive-controlled homing completed
    logic                  axis_moving;      // control unit reports axis in motion
    logic [`DSH_CFG_W-1:0] safety_cfg;       // safety configuration word
    dsh_pos_t              tol_window;       // tolerance window
    dsh_pos_t              ref_pos;          // reference position for safe reference
    logic [2:0]            comm_phase;       // communication phase
    logic [`DSH_STS_W-1:0] op_status;        // safety operating status
    logic                  safe_homing_error_diag; // homing failed, pulse
    modport dev (
        input  ch2_cmd_start, drv_homing_start, drv_homing_done, axis_moving,
               safety_cfg, tol_window, ref_pos, comm_phase,
        output op_status, safe_homing_error_diag
    );
    modport ctl (
        output ch2_cmd_start, drv_homing_start, drv_homing_done, axis_moving,
               safety_cfg, tol_window, ref_pos, comm_phase,
        input  op_status, safe_homing_error_diag
    );
endinterface : dsh_if

// ### verilog/dsh_control.sv
// dsh_control.sv: motion control unit end that issues homing commands
// assumes the device end shares sys_clk; travel is reported, not generated here
`timescale 1ns/1ps
`include "dsh_map.svh"
module dsh_control
    import dsh_pkg::*;
#(
    parameter int POS_W = `DSH_POS_W
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    dsh_if.ctl                         link,
    input  wire logic                  req_ch2_home,   // user asks for channel 2 homing
    input  wire logic                  req_drv_home,   // user asks for drive-controlled homing
    input  wire logic                  ch1_homed,      // channel 1 holds a valid reference
    input  wire logic                  drv_travel_end, // drive homing travel finished
    input  wire logic                  travel_active,  // control unit is moving the axis
    input  wire logic [`DSH_CFG_W-1:0] cfg_in,         // configuration to apply
    input  wire logic [POS_W-1:0]      tol_in,         // tolerance window to apply
    input  wire logic [POS_W-1:0]      ref_in,         // reference position to apply
    input  wire logic [2:0]            phase_in,       // communication phase
    output logic                       need_nc_travel, // own travel needed to actuate switch
    output logic                       safely_homed,   // device reports safe reference
    output logic                       homing_failed   // device reported an error
);
    logic drv_run_ff;   // drive-controlled homing in progress

    // command strobes; channel 2 start only when channel 1 is homed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.ch2_cmd_start    <= 1'b0;
            link.drv_homing_start <= 1'b0;
            link.drv_homing_done  <= 1'b0;
        end else begin
            link.ch2_cmd_start    <= req_ch2_home && ch1_homed;
            link.drv_homing_start <= req_drv_home && !drv_run_ff;
            link.drv_homing_done  <= drv_run_ff && drv_travel_end;
        end
    end

    // drive homing tracking; after travel without reference, own motion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_run_ff     <= 1'b0;
            need_nc_travel <= 1'b0;
        end else begin
            if (req_drv_home && !drv_run_ff) begin
                drv_run_ff <= 1'b1;
            end else if (drv_travel_end) begin
                drv_run_ff <= 1'b0;
            end
            need_nc_travel <= drv_travel_end
                && !link.op_status[`DSH_STS_HOMED_BIT]
                && link.op_status[`DSH_STS_BUSY_BIT];
        end
    end

    // configuration and motion report; motion comes from this side only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link.axis_moving <= 1'b0;
            link.safety_cfg  <= '0;
            link.tol_window  <= '0;
            link.ref_pos     <= '0;
            link.comm_phase  <= 3'h0;
        end else begin
            link.axis_moving <= travel_active;
            link.safety_cfg  <= cfg_in;
            link.tol_window  <= tol_in;
            link.ref_pos     <= ref_in;
            link.comm_phase  <= phase_in;
        end
    end

    // status seen by the user
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            safely_homed  <= 1'b0;
            homing_failed <= 1'b0;
        end else begin
            safely_homed  <= link.op_status[`DSH_STS_HOMED_BIT];
            homing_failed <= link.safe_homing_error_diag;
        end
    end
endmodule : dsh_control

// ### bench/dsh_checker.sv
// dsh_checker.sv: link-level checks of the safe homing device end
// assumes the bench hands in the signals of the one dsh_if instance
`timescale 1ns/1ps
`include "dsh_map.svh"
module dsh_checker
    import dsh_pkg::*;
(
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire logic                  ch2_cmd_start,
    input wire logic                  drv_homing_start,
    input wire logic                  drv_homing_done,
    input wire logic                  axis_moving,
    input wire logic [`DSH_CFG_W-1:0] safety_cfg,
    input wire dsh_pos_t              tol_window,
    input wire dsh_pos_t              ref_pos,
    input wire logic [2:0]            comm_phase,
    input wire logic [`DSH_STS_W-1:0] op_status,
    input wire logic                  safe_homing_error_diag
);
    // status bits split out for readability
    wire homed = op_status[`DSH_STS_HOMED_BIT];
    wire busy  = op_status[`DSH_STS_BUSY_BIT];
    wire smp   = op_status[`DSH_STS_SMP_BIT];
    wire err   = safe_homing_error_diag;
    wire run   = (comm_phase == `DSH_PHASE_RUN);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // homed, in phase 4, with no start on the link
    sequence s_quiet;
        homed && run && !ch2_cmd_start && !drv_homing_start;
    endsequence
    // a parameter start that the idle device must take
    sequence s_ch2_go;
        ch2_cmd_start && run && !busy && !homed;
    endsequence
    // drive homing start without monitored position configured
    sequence s_drv_bare;
        drv_homing_start && !safety_cfg[`DSH_CFG_SMP_BIT] && !ch2_cmd_start && !busy ##1 !busy;
    endsequence

    a_start_gives_busy: assert property (s_ch2_go |-> ##2 busy)
        else $error("parameter start did not raise busy");
    a_drv_auto_start: assert property (drv_homing_start && safety_cfg[`DSH_CFG_SMP_BIT]
        && run && !busy && !homed |-> ##2 busy)
        else $error("drive homing did not start channel 2 command");
    a_drv_no_auto: assert property (s_drv_bare |-> ##1 !busy)
        else $error("drive homing started channel 2 without monitored position");
    a_homed_holds: assert property (s_quiet [*3] |=> homed)
        else $error("safe reference lost without cause");
    a_phase_clears: assert property (!run [*3] |-> !homed)
        else $error("safe reference kept outside phase 4");
    a_err_one_pulse: assert property (err |=> !err)
        else $error("error diagnostic longer than one cycle");
    a_err_not_homed: assert property (err |-> !homed)
        else $error("homed reported together with error");
    a_smp_needs_homed: assert property (smp |-> homed)
        else $error("monitored position permitted without reference");
    a_homed_after_run: assert property ($rose(homed) |-> $past(busy))
        else $error("homed rose without a running command");
    a_err_after_run: assert property ($rose(err) |-> $past(busy))
        else $error("error rose without a running command");
    // drive homing completion is reported once per finished travel
    a_done_one_pulse: assert property (drv_homing_done |=> !drv_homing_done)
        else $error("drive homing done longer than one cycle");
endmodule : dsh_checker

// ### bench/tb_dual_channel_safe_homing.sv
// tb_dual_channel_safe_homing.sv: both ends joined, scenarios judged here
// assumes dsh_pkg and dsh_if are compiled first; one 250 MHz clock
`timescale 1ns/1ps
`include "dsh_map.svh"
module tb_dual_channel_safe_homing;
    import dsh_pkg::*;
    localparam logic [31:0] REF = 32'h0000_1000;   // reference position
    localparam logic [31:0] TOL = 32'h0000_0010;   // tolerance window
    logic        sys_clk, rst_n, home_switch, ch2_start_in, ch2_homed, no_motion_req;
    logic [31:0] fb1_pos, fb2_pos, ch2_raw_pos, ch2_actual_pos;
    logic        req_ch2_home, req_drv_home, ch1_homed, drv_travel_end, travel_active;
    logic [3:0]  cfg_in;
    logic [2:0]  phase_in;
    logic        need_nc_travel, safely_homed, homing_failed;
    int          fails, checks_done;
    dsh_if link ();
    dsh_device u_dsh_device (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .home_switch(home_switch), .ch2_start_in(ch2_start_in), .fb1_pos(fb1_pos),
        .fb2_pos(fb2_pos), .ch2_raw_pos(ch2_raw_pos), .ch2_actual_pos(ch2_actual_pos),
        .ch2_homed(ch2_homed), .no_motion_req(no_motion_req));
    dsh_control u_dsh_control (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .req_ch2_home(req_ch2_home), .req_drv_home(req_drv_home), .ch1_homed(ch1_homed),
        .drv_travel_end(drv_travel_end), .travel_active(travel_active), .cfg_in(cfg_in),
        .tol_in(TOL), .ref_in(REF), .phase_in(phase_in), .need_nc_travel(need_nc_travel),
        .safely_homed(safely_homed), .homing_failed(homing_failed));
    dsh_checker u_dsh_checker (.sys_clk(sys_clk), .rst_n(rst_n),
        .ch2_cmd_start(link.ch2_cmd_start), .drv_homing_start(link.drv_homing_start),
        .drv_homing_done(link.drv_homing_done), .axis_moving(link.axis_moving),
        .safety_cfg(link.safety_cfg), .tol_window(link.tol_window), .ref_pos(link.ref_pos),
        .comm_phase(link.comm_phase), .op_status(link.op_status),
        .safe_homing_error_diag(link.safe_homing_error_diag));

    // clock: invert each half period
    always #2 sys_clk = ~sys_clk;

    // verdict and end of run, also reached from a spent wait
    task automatic close_out;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // compare one result, report at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // bounded wait: 0 busy, 1 homed, 2 failed, 3 travel needed
    task automatic wt(input int s);
        logic hit;
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            hit = (s == 0) ? link.op_status[`DSH_STS_BUSY_BIT] : (s == 1) ? safely_homed
                : (s == 2) ? homing_failed : need_nc_travel;
            if (hit === 1'b1) return;
        end
        fails++;
        close_out();
    endtask : wt
    // static switch: moving must not home, standstill at boundary tolerance must
    task automatic s_static;
        cfg_in = 4'h5; fb1_pos = REF + TOL; home_switch = 1'b1; travel_active = 1'b1;
        req_ch2_home = 1'b1;
        wt(0);
        req_ch2_home = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk(safely_homed, 1'b0);
        travel_active = 1'b0;
        wt(1);
        chk(link.op_status[`DSH_STS_SMP_BIT], 1'b1);
        repeat (2) @(negedge sys_clk);
        chk(ch2_actual_pos, fb1_pos);
        chk(ch2_homed, 1'b1);
        chk(no_motion_req, 1'b0);
        home_switch = 1'b0;
    endtask : s_static
    // leaving phase 4 drops the reference
    task automatic s_phase;
        phase_in = 3'h3;
        repeat (4) @(negedge sys_clk);
        chk(safely_homed, 1'b0);
        chk(ch2_homed, 1'b0);
        phase_in = 3'h4;
        @(negedge sys_clk);
    endtask : s_phase
    // dynamic, both polarities, digital input start; wrong edge ignored first
    task automatic s_dyn;
        for (int e = 0; e < 2; e++) begin
            cfg_in = {2'b00, e[0], 1'b0}; fb1_pos = REF + 32'h3; travel_active = 1'b1;
            home_switch = e[0]; ch2_start_in = 1'b1;
            wt(0);
            ch2_start_in = 1'b0; home_switch = ~e[0];
            repeat (6) @(negedge sys_clk);
            chk(safely_homed, 1'b0);
            home_switch = e[0];
            wt(1);
            travel_active = 1'b0;
            s_phase();
        end
    endtask : s_dyn
    // one increment outside tolerance fails and stays unhomed
    task automatic s_fail;
        cfg_in = 4'h5; fb1_pos = REF + TOL + 32'h1; home_switch = 1'b1; req_ch2_home = 1'b1;
        wt(0);
        req_ch2_home = 1'b0;
        wt(2);
        chk(safely_homed, 1'b0);
        chk(ch2_homed, 1'b0);
        home_switch = 1'b0;
    endtask : s_fail
    // drive homing: no auto start without monitored position, then ext encoder
    task automatic s_drv;
        cfg_in = 4'h9; req_drv_home = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(link.op_status[`DSH_STS_BUSY_BIT], 1'b0);
        // end the first drive homing, else the control end never starts a second one
        req_drv_home = 1'b0; drv_travel_end = 1'b1;
        cfg_in = 4'hd; fb2_pos = REF + 32'h3; fb1_pos = REF + 32'h100;
        @(negedge sys_clk);
        drv_travel_end = 1'b0;
        req_drv_home = 1'b1;
        wt(0);
        req_drv_home = 1'b0; drv_travel_end = 1'b1;
        wt(3);
        home_switch = 1'b1;
        wt(1);
        repeat (2) @(negedge sys_clk);
        chk(ch2_actual_pos, fb2_pos);
        drv_travel_end = 1'b0; home_switch = 1'b0;
    endtask : s_drv
    // no channel 1 reference: control must not start channel 2
    task automatic s_noch1;
        ch1_homed = 1'b0; req_ch2_home = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(link.op_status[`DSH_STS_BUSY_BIT], 1'b0);
        req_ch2_home = 1'b0; ch1_homed = 1'b1;
    endtask : s_noch1

    // main sequence
    initial begin
        sys_clk = 1'b0; rst_n = 1'b0; home_switch = 1'b0; ch2_start_in = 1'b0;
        fb1_pos = REF; fb2_pos = REF; ch2_raw_pos = 32'h0000_0500; req_ch2_home = 1'b0;
        req_drv_home = 1'b0; ch1_homed = 1'b1; drv_travel_end = 1'b0; travel_active = 1'b0;
        cfg_in = 4'h0; phase_in = 3'h4; fails = 0; checks_done = 0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        s_static();
        s_phase();
        s_dyn();
        s_fail();
        s_phase();
        s_drv();
        s_noch1();
        close_out();
    end
endmodule : tb_dual_channel_safe_homing
